/* dic_top.v */
// The implementer's own choices: the register offsets and the APB slave port.
`include "dic_consts.vh"

module dic_top #(
	parameter MS_CYCLES = `DIC_MS_NS / `DIC_CLK_PERIOD_NS
) (
	input  wire                                pclk,
	input  wire                                presetn,
	input  wire                                ce,
	input  wire                                psel,
	input  wire                                penable,
	input  wire                                pwrite,
	input  wire [11:0]                         paddr,
	input  wire [31:0]                         pwdata,
	output reg  [31:0]                         prdata,
	output reg                                 pready,
	output reg                                 pslverr,
	input  wire [`DIC_NUM_CH*`DIC_VOLT_W-1:0]  input_channel_volt,
	output reg  [`DIC_NUM_CH-1:0]              input_channel_state,
	output reg  [`DIC_NUM_RELAY-1:0]           relay_output
);

	localparam MS_W = 17;
	localparam integer MS_LAST_I = (MS_CYCLES > 1) ? MS_CYCLES - 1 : 0;
	localparam [MS_W-1:0] MS_LAST = MS_LAST_I[MS_W-1:0];

	reg  [MS_W-1:0]               ms_cnt;
	reg                           ms_tick;
	reg  [2:0]                    scan_cnt;
	reg                           scan_tick;
	reg  [`DIC_NUM_RELAY-1:0]     relay_ctl;

	reg  [`DIC_NUM_CH-1:0]        pol;
	reg  [`DIC_NUM_CH-1:0]        ac_en;
	reg  [`DIC_NUM_CH-1:0]        clr;
	reg  [`DIC_TH_W-1:0]          act_th   [0:`DIC_NUM_CH-1];
	reg  [`DIC_TH_W-1:0]          rel_th   [0:`DIC_NUM_CH-1];
	reg  [`DIC_DLY_W-1:0]         act_dly  [0:`DIC_NUM_CH-1];
	reg  [`DIC_DLY_W-1:0]         drop_dly [0:`DIC_NUM_CH-1];
	reg  [`DIC_VOLT_W-1:0]        volt_now [0:`DIC_NUM_CH-1];
	wire [`DIC_CNT_W-1:0]         count    [0:`DIC_NUM_CH-1];
	wire [`DIC_NUM_CH-1:0]        qual;

	wire                          access;
	wire                          wr_en;
	wire                          ch_hit;
	wire [2:0]                    ch_sel;
	wire [2:0]                    ch_reg;
	reg  [31:0]                   next_prdata;
	reg                           next_pslverr;

	// Slave inserts one wait state so read data comes straight from a flop
	assign access = psel & penable & ~pready;
	assign wr_en  = psel & penable & pready & pwrite & ~pslverr;
	assign ch_hit = (paddr[11:8] == `DIC_CH_BASE_HI) && (paddr[4:2] <= `DIC_CH_VOLT);
	assign ch_sel = paddr[7:5];
	assign ch_reg = paddr[4:2];

	// Millisecond base and scan divider
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt    <= {MS_W{1'b0}};
			ms_tick   <= 1'b0;
			scan_cnt  <= 3'h0;
			scan_tick <= 1'b0;
		end else if (ce) begin
			ms_tick   <= 1'b0;
			scan_tick <= 1'b0;
			if (ms_cnt >= MS_LAST) begin
				ms_cnt  <= {MS_W{1'b0}};
				ms_tick <= 1'b1;
				if (scan_cnt == `DIC_SCAN_MS - 1) begin
					scan_cnt  <= 3'h0;
					scan_tick <= 1'b1;
				end else begin
					scan_cnt <= scan_cnt + 1'b1;
				end
			end else begin
				ms_cnt <= ms_cnt + 1'b1;
			end
		end
	end

	// Scan-synchronous snapshots: input states and relay contacts
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_channel_state <= {`DIC_NUM_CH{1'b0}};
			relay_output        <= {`DIC_NUM_RELAY{1'b0}};
		end else if (ce && scan_tick) begin
			input_channel_state <= qual;
			relay_output        <= relay_ctl;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `DIC_NUM_CH; g = g + 1) begin : g_ch
			wire sel_w = wr_en && ch_hit && (ch_sel == g);

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pol[g]      <= 1'b0;
					ac_en[g]    <= 1'b0;
					clr[g]      <= 1'b0;
					act_th[g]   <= `DIC_ACT_TH_RST;
					rel_th[g]   <= `DIC_REL_TH_RST;
					act_dly[g]  <= `DIC_DLY_RST;
					drop_dly[g] <= `DIC_DLY_RST;
					volt_now[g] <= {`DIC_VOLT_W{1'b0}};
				end else if (ce) begin
					clr[g] <= 1'b0;
					if (scan_tick)
						volt_now[g] <= input_channel_volt[g*`DIC_VOLT_W +: `DIC_VOLT_W];
					if (sel_w) begin
						case (ch_reg)
							`DIC_CH_CFG: begin
								pol[g]   <= pwdata[`DIC_CFG_POL_BIT];
								ac_en[g] <= pwdata[`DIC_CFG_AC_BIT];
								clr[g]   <= pwdata[`DIC_CFG_CLR_BIT];
							end
							`DIC_CH_ACT_TH:   act_th[g]   <= pwdata[`DIC_TH_W-1:0];
							`DIC_CH_REL_TH:   rel_th[g]   <= pwdata[`DIC_TH_W-1:0];
							`DIC_CH_ACT_DLY:  act_dly[g]  <= pwdata[`DIC_DLY_W-1:0];
							`DIC_CH_DROP_DLY: drop_dly[g] <= pwdata[`DIC_DLY_W-1:0];
							default: ;
						endcase
					end
				end
			end

			dic_chan u_chan (
				.pclk      (pclk),
				.presetn   (presetn),
				.ce        (ce),
				.scan_tick (scan_tick),
				.ms_tick   (ms_tick),
				.volt_mv   (input_channel_volt[g*`DIC_VOLT_W +: `DIC_VOLT_W]),
				.pol       (pol[g]),
				.ac_en     (ac_en[g]),
				.act_th    (act_th[g]),
				.rel_th    (rel_th[g]),
				.act_dly   (act_dly[g]),
				.drop_dly  (drop_dly[g]),
				.clr       (clr[g]),
				.qual      (qual[g]),
				.count     (count[g])
			);
		end
	endgenerate

	// Relay command register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			relay_ctl <= {`DIC_NUM_RELAY{1'b0}};
		else if (ce && wr_en && paddr == `DIC_REG_RELAY_CTL)
			relay_ctl <= pwdata[`DIC_NUM_RELAY-1:0];
	end

	// Read mux and decode error
	always @* begin
		next_prdata  = 32'h00000000;
		next_pslverr = 1'b0;
		if (ch_hit) begin
			case (ch_reg)
				`DIC_CH_CFG:      next_prdata = {30'h00000000, ac_en[ch_sel], pol[ch_sel]};
				`DIC_CH_ACT_TH:   next_prdata = {20'h00000, act_th[ch_sel]};
				`DIC_CH_REL_TH:   next_prdata = {20'h00000, rel_th[ch_sel]};
				`DIC_CH_ACT_DLY:  next_prdata = {11'h000, act_dly[ch_sel]};
				`DIC_CH_DROP_DLY: next_prdata = {11'h000, drop_dly[ch_sel]};
				`DIC_CH_COUNT:    next_prdata = count[ch_sel];
				`DIC_CH_VOLT:     next_prdata = {13'h0000, volt_now[ch_sel]};
				default:          next_prdata = 32'h00000000;
			endcase
		end else begin
			case (paddr)
				`DIC_REG_STATUS:      next_prdata = {24'h000000, input_channel_state};
				`DIC_REG_RELAY_CTL:   next_prdata = {27'h0000000, relay_ctl};
				`DIC_REG_RELAY_STATE: next_prdata = {27'h0000000, relay_output};
				default:              next_pslverr = 1'b1;
			endcase
		end
		if (paddr[1:0] != 2'h0)
			next_pslverr = 1'b1;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			pready  <= access;
			pslverr <= access & next_pslverr;
			if (access && !pwrite)
				prdata <= next_pslverr ? 32'h00000000 : next_prdata;
		end
	end

endmodule

/* dic_consts.vh */
// Contract
// - Polarity 0 NO energized reads 1, NC reads 0
// - Above activation threshold energizes input; 0.1 V steps
// - Below release threshold de-energizes; default 60 V
// - Zero-to-one change waits activation delay, ms steps
// - One-to-zero change waits drop-off delay, ms steps
// - AC mode adds 30 ms deactivation delay
// - AC mode release threshold is activation/10
// - 32-bit counter counts qualified rising changes
// - Clear command zeroes counter, reads back 0
// - Every setting held separately per channel
// - Channel voltage reported in millivolts
// - Five relay outputs updated once per scan
// - Inputs sampled once per 5 ms scan
// - Eight input channels, each own settings
`ifndef DIC_CONSTS_VH
`define DIC_CONSTS_VH

`define DIC_NUM_CH          8
`define DIC_NUM_RELAY       5
`define DIC_VOLT_W          19
`define DIC_TH_W            12
`define DIC_DLY_W           21
`define DIC_TMR_W           22
`define DIC_CNT_W           32

`define DIC_CLK_PERIOD_NS   8
`define DIC_MS_NS           1000000
`define DIC_SCAN_MS         5
`define DIC_AC_EXTRA_MS     30
`define DIC_MV_PER_STEP     100
`define DIC_AC_DIV          10

`define DIC_ACT_TH_RST      12'h320
`define DIC_REL_TH_RST      12'h258
`define DIC_DLY_RST         21'h000000

`define DIC_REG_STATUS      12'h000
`define DIC_REG_RELAY_CTL   12'h004
`define DIC_REG_RELAY_STATE 12'h008
`define DIC_CH_BASE_HI      4'h1
`define DIC_CH_CFG          3'h0
`define DIC_CH_ACT_TH       3'h1
`define DIC_CH_REL_TH       3'h2
`define DIC_CH_ACT_DLY      3'h3
`define DIC_CH_DROP_DLY     3'h4
`define DIC_CH_COUNT        3'h5
`define DIC_CH_VOLT         3'h6

`define DIC_CFG_POL_BIT     0
`define DIC_CFG_AC_BIT      1
`define DIC_CFG_CLR_BIT     2

`endif

/* dic_chan.v */
`include "dic_consts.vh"

module dic_chan (
	input  wire                      pclk,
	input  wire                      presetn,
	input  wire                      ce,
	input  wire                      scan_tick,
	input  wire                      ms_tick,
	input  wire [`DIC_VOLT_W-1:0]    volt_mv,
	input  wire                      pol,
	input  wire                      ac_en,
	input  wire [`DIC_TH_W-1:0]      act_th,
	input  wire [`DIC_TH_W-1:0]      rel_th,
	input  wire [`DIC_DLY_W-1:0]     act_dly,
	input  wire [`DIC_DLY_W-1:0]     drop_dly,
	input  wire                      clr,
	output reg                       qual,
	output reg  [`DIC_CNT_W-1:0]     count
);

	reg                    energized;
	reg  [`DIC_TMR_W-1:0]  tmr;
	wire [31:0]            act_full;
	wire [31:0]            rel_full;
	wire [31:0]            need_full;
	wire [`DIC_VOLT_W-1:0] act_mv;
	wire [`DIC_VOLT_W-1:0] rel_mv;
	wire [`DIC_TMR_W-1:0]  need;
	wire                   raw;
	wire                   expired;

	// Products are formed wide, then cut: the largest setting still fits in mV
	assign act_full = act_th * `DIC_MV_PER_STEP;
	// In AC mode the release point is a tenth of activation, in mV directly
	assign rel_full = ac_en ? act_th * (`DIC_MV_PER_STEP / `DIC_AC_DIV)
	                        : rel_th * `DIC_MV_PER_STEP;
	assign act_mv = act_full[`DIC_VOLT_W-1:0];
	assign rel_mv = rel_full[`DIC_VOLT_W-1:0];
	assign raw = energized ^ pol;
	assign need_full = qual ? (drop_dly + (ac_en ? `DIC_AC_EXTRA_MS : 0))
	                        : act_dly;
	assign need = need_full[`DIC_TMR_W-1:0];
	assign expired = (tmr >= need);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energized <= 1'b0;
			tmr       <= {`DIC_TMR_W{1'b0}};
			qual      <= 1'b0;
			count     <= {`DIC_CNT_W{1'b0}};
		end else if (ce) begin
			if (scan_tick) begin
				if (volt_mv > act_mv)
					energized <= 1'b1;
				else if (volt_mv < rel_mv)
					energized <= 1'b0;
			end
			if (raw == qual)
				tmr <= {`DIC_TMR_W{1'b0}};
			else if (expired) begin
				qual <= raw;
				tmr  <= {`DIC_TMR_W{1'b0}};
			end else if (ms_tick)
				tmr <= tmr + 1'b1;
			// Increment after a clear in the same cycle so no edge is lost
			if (raw != qual && expired && raw)
				count <= (clr ? {`DIC_CNT_W{1'b0}} : count) + 1'b1;
			else if (clr)
				count <= {`DIC_CNT_W{1'b0}};
		end
	end

endmodule

/* dic_field.sv */
module dic_field (
	input  logic         pclk,
	input  logic [151:0] set_mv,
	output logic [151:0] volt
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sources settle one clock after the bench asks, on whichever edge that is, scan edges included
	always @(posedge pclk) begin
		volt <= set_mv;
	end
endmodule

/* dic_sva.sv */
module dic_sva (
	input logic        pclk,
	input logic        presetn,
	input logic        ce,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic [7:0]  input_channel_state,
	input logic [4:0]  relay_output
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_ok = pready && !pwrite && !pslverr;
	wire chan  = paddr[11:8] != 4'h0;
	chk_ready_answer: assert property (psel && penable && !pready && ce |=> pready) else $error("no answer");
	chk_ready_pulse: assert property (pready && ce |=> !pready) else $error("pready too long");
	chk_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned taken");
	chk_err_ready: assert property (pslverr |-> pready) else $error("stray error");
	chk_status_read: assert property (rd_ok && paddr == 12'h000 |-> prdata == {24'h0, $past(input_channel_state)})
		else $error("status read");
	chk_clear_idle: assert property (rd_ok && chan && paddr[4:0] == 5'h00 |-> prdata[31:2] == 30'h0)
		else $error("config read");
	chk_th_width: assert property (rd_ok && chan && (paddr[4:0] == 5'h04 || paddr[4:0] == 5'h08)
		|-> prdata[31:12] == 20'h0) else $error("threshold read");
	chk_volt_width: assert property (rd_ok && chan && paddr[4:0] == 5'h18 |-> prdata[31:19] == 13'h0)
		else $error("voltage read");
	chk_state_scan: assert property ($changed(input_channel_state) |=> $stable(input_channel_state) [*8])
		else $error("state off scan");
	chk_relay_scan: assert property ($changed(relay_output) |=> $stable(relay_output) [*8])
		else $error("relay off scan");
	chk_freeze_ce: assert property (!ce |=> $stable(input_channel_state) && $stable(relay_output))
		else $error("moved while frozen");
	cover property (pready && pwrite);
	cover property (pslverr);
	cover property ($rose(input_channel_state[0]));
endmodule
bind dic_top dic_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.input_channel_state(input_channel_state), .relay_output(relay_output));

/* dic_top_tb.sv */
module dic_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SCAN = 100;
	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	logic         ce = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [151:0] set_mv = 152'h0;
	logic [151:0] volt;
	logic [31:0]  prdata, rd;
	logic         pready, pslverr, er;
	logic [7:0]   state, pol, en;
	logic [4:0]   relay, rly;
	logic [11:0]  act [8];
	int           bad_count = 0;
	int           num_checks = 0;
	int           t;
	initial forever #4 pclk = ~pclk;
	dic_field fld (.pclk(pclk), .set_mv(set_mv), .volt(volt));
	dic_top #(.MS_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.input_channel_volt(volt), .input_channel_state(state), .relay_output(relay));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			bad_count++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle keeps one assignment per signal per time step
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic wait_state(input logic v);
		t = 0;
		while (state[0] !== v && t < 3000) begin
			@(posedge pclk);
			t++;
		end
		if (t >= 3000) begin
			bad_count++;
			test_done();
		end
	endtask
	function automatic logic [11:0] ch(input int n, input logic [4:0] off);
		return 12'h100 + 12'(n * 32) + {7'h0, off};
	endfunction
	function automatic logic [18:0] mv(input logic [11:0] th, input int d);
		return 19'(th) * 19'h64 + 19'(d);
	endfunction
	initial begin
		rly = 5'($urandom(50));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(ch(3, 5'h04), 32'h320);
		rdc(ch(3, 5'h08), 32'h258);
		rdc(ch(3, 5'h0c), 32'h0);
		rdc(ch(3, 5'h10), 32'h0);
		rdc(ch(3, 5'h00), 32'h0);
		rdc(ch(3, 5'h14), 32'h0);
		apb(1'b0, ch(2, 5'h1c), 32'h0);
		check(er, 1'b1);
		apb(1'b1, 12'h006, 32'h1);
		check(er, 1'b1);
		apb(1'b1, 12'h004, {27'h0, rly});
		repeat (2 * SCAN) @(posedge pclk);
		check(relay, rly);
		rdc(12'h008, {27'h0, rly});
		repeat (2) begin
			pol = 8'($urandom());
			en = 8'($urandom());
			for (int i = 0; i < 8; i++) begin
				act[i] = 12'(160 + $urandom_range(1840));
				apb(1'b1, ch(i, 5'h00), {31'h0, pol[i]});
				apb(1'b1, ch(i, 5'h04), {20'h0, act[i]});
				apb(1'b1, ch(i, 5'h08), {20'h0, act[i] - 12'h032});
				set_mv[i*19+:19] <= en[i] ? mv(act[i], 1) : mv(act[i], -5001);
			end
			repeat (3 * SCAN) @(posedge pclk);
			check(state, en ^ pol);
			rdc(12'h000, {24'h0, en ^ pol});
			// Exactly on a threshold must not count as crossing it
			for (int i = 0; i < 8; i++) set_mv[i*19+:19] <= en[i] ? mv(act[i], -5000) : mv(act[i], 0);
			repeat (3 * SCAN) @(posedge pclk);
			check(state, en ^ pol);
			rdc(ch(5, 5'h18), {13'h0, set_mv[5*19+:19]});
		end
		apb(1'b1, ch(0, 5'h00), 32'h0);
		apb(1'b1, ch(0, 5'h04), 32'h1f4);
		apb(1'b1, ch(0, 5'h08), 32'h12c);
		apb(1'b1, ch(0, 5'h0c), 32'hc);
		apb(1'b1, ch(0, 5'h10), 32'h8);
		set_mv[18:0] <= 19'h0;
		repeat (3 * SCAN) @(posedge pclk);
		apb(1'b1, ch(0, 5'h00), 32'h4);
		rdc(ch(0, 5'h14), 32'h0);
		rdc(ch(0, 5'h00), 32'h0);
		// Two 10 ms pulses: only a timer that restarts keeps each under 12 ms
		repeat (2) begin
			set_mv[18:0] <= 19'hea60;
			repeat (2 * SCAN) @(posedge pclk);
			set_mv[18:0] <= 19'h0;
			repeat (3 * SCAN) @(posedge pclk);
			check(state[0], 1'b0);
		end
		set_mv[18:0] <= 19'hea60;
		wait_state(1'b1);
		check(32'(t >= 240 && t <= 480), 32'h1);
		rdc(ch(0, 5'h14), 32'h1);
		set_mv[18:0] <= 19'h0;
		wait_state(1'b0);
		check(32'(t >= 160 && t <= 380), 32'h1);
		apb(1'b1, ch(0, 5'h00), 32'h2);
		set_mv[18:0] <= 19'hea60;
		wait_state(1'b1);
		set_mv[18:0] <= 19'h1770;
		repeat (8 * SCAN) @(posedge pclk);
		check(state[0], 1'b1);
		set_mv[18:0] <= 19'hfa0;
		wait_state(1'b0);
		check(32'(t >= 760 && t <= 1000), 32'h1);
		rdc(ch(0, 5'h14), 32'h2);
		ce <= 1'b0;
		set_mv[18:0] <= 19'hea60;
		repeat (2 * SCAN) @(posedge pclk);
		check(state[0], 1'b0);
		ce <= 1'b1;
		@(posedge pclk);
		// Mid-run reset must bring back every default and empty the counters
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check(relay, 5'h0);
		check(state, 8'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(ch(0, 5'h14), 32'h0);
		rdc(ch(0, 5'h04), 32'h320);
		test_done();
	end
endmodule
